// >>> hw/flag_sync.sv
// Two-stage synchroniser for a bundle of asynchronous flags
`timescale 1ns/1ns
module flag_sync
#(
  parameter int          WIDTH      = 13,
  parameter logic [12:0] RESET_BITS = 13'h0000
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // Parameter check
  if (WIDTH < 1 || WIDTH > 13)
  begin : g_bad_width
    $error("flag_sync width out of range");
  end

  typedef struct packed
  {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // ==========================================================================
  // Stage chain
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.stage1 = async_in;
    st_nxt.stage2 = st_r.stage1;
    if (!rst_b)
    begin
      st_nxt.stage1 = RESET_BITS[WIDTH-1:0];
      st_nxt.stage2 = RESET_BITS[WIDTH-1:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    st_r <= st_nxt;
  end

  assign sync_out = st_r.stage2;

endmodule

// >>> hw/regsup_pkg.sv
// Constants and types shared by the regulator supervisor files
package regsup_pkg;

  // ==========================================================================
  // Register map
  localparam int         ADDR_W          = 8;
  localparam int         DATA_W          = 8;
  localparam logic [7:0] REG_CTRL_OFF    = 8'h10;
  localparam logic [7:0] REG_SUP_CFG_OFF = 8'h20;
  localparam logic [7:0] REG_STATUS_OFF  = 8'h21;

  // ==========================================================================
  // Regulator control fields
  localparam int         THR_LSB       = 0;
  localparam int         SEC_EN_LSB    = 2;
  localparam int         POLICY_LSB    = 4;
  localparam logic [7:0] CTRL_WR_MASK  = 8'h3F;
  localparam logic [1:0] POLICY_RESET  = 2'h0;
  localparam logic [1:0] THR_90PCT     = 2'h0;

  // ==========================================================================
  // Supply configuration fields
  localparam int         CFG_AUTO_REDUCE_BIT = 0;
  localparam int         CFG_PRI_UV_IE_BIT   = 1;
  localparam logic [7:0] CFG_WR_MASK         = 8'h03;
  localparam logic [7:0] CFG_RESET           = 8'h00;

  // ==========================================================================
  // Supply status fields
  localparam int STAT_PRI_BIT    = 0;
  localparam int STAT_AUX_UV_BIT = 1;
  localparam int STAT_AUX_OV_BIT = 2;
  localparam int STAT_OTW_BIT    = 3;

  // ==========================================================================
  // Synchroniser bundle layout
  localparam int             SYNC_W       = 13;
  localparam int             S_BAT_OV     = 0;
  localparam int             S_BAT_UV     = 1;
  localparam int             S_AUX_OV     = 2;
  localparam int             S_AUX_UV     = 3;
  localparam int             S_PRI_LSB    = 4;
  localparam int             S_OTW        = 8;
  localparam int             S_VAR_3V3    = 9;
  localparam int             S_EXT_RST_B  = 10;
  localparam int             S_SPARE_LSB  = 11;
  localparam logic [12:0]    SYNC_RESET   = 13'h0400;

  // ==========================================================================
  // Device operating mode, one-hot
  typedef enum logic [4:0]
  {
    MODE_NORMAL    = 5'b0_0001,
    MODE_STANDBY   = 5'b0_0010,
    MODE_SLEEP     = 5'b0_0100,
    MODE_RESET     = 5'b0_1000,
    MODE_FAIL_SAFE = 5'b1_0000
  } op_mode_t;

endpackage

// >>> hw/regulator_supervisor_control.sv
// Regulator control register, supply supervision and reset generation
//
// Function
// - Auto-reduce enabled and overtemperature warning lower the switched-mode setpoint to 5 V.
// - Auto-reduce enable clears at power-up and on an external reset pulse.
// - Overtemperature warning status reads 1 while temperature exceeds warning threshold.
// - System reset while primary output is below the selected threshold.
// - Threshold field bits 1:0: 00=90%, 01=80%, 10=70%, 11=60%.
// - Threshold field loads its startup value from non-volatile configuration.
// - 3.3 V variant always uses the 90 % threshold.
// - Primary below 90 % with enable set raises primary undervoltage interrupt.
// - Primary status bit reports primary output above or below 90 %.
// - Auxiliary pass transistor off during overvoltage, back on when it clears.
// - Auxiliary undervoltage and overvoltage raise their interrupts.
// - Auxiliary status bits show present auxiliary voltage condition.
// - Secondary enable bits 3:2 select the operating modes where it runs.
// - Secondary enable field loads its startup value from non-volatile configuration.
// - Policy bits 5:4 shut secondary off on battery undervoltage, overvoltage, both.
`timescale 1ns/1ns
module regulator_supervisor_control
#(
  parameter int REG_ADDR_W = 8
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  input  wire regsup_pkg::op_mode_t  op_mode,
  input  wire logic [1:0]            primary_threshold_startup_default,
  input  wire logic [1:0]            secondary_startup_default,
  input  wire logic                  aux_connection_config,
  input  wire logic                  external_reset_pin_b,
  input  wire logic                  variant_3v3,
  input  wire logic                  overtemp_warn_cmp,
  input  wire logic [3:0]            primary_below_cmp,
  input  wire logic                  aux_below_90_cmp,
  input  wire logic                  aux_above_110_cmp,
  input  wire logic                  battery_undervoltage,
  input  wire logic                  battery_overvoltage,
  output logic                       system_reset,
  output logic                       switched_mode_supply_setpoint_reduce_5v,
  output logic                       secondary_regulator_enable,
  output logic                       aux_pass_enable,
  output logic [1:0]                 primary_reset_threshold_eff,
  output logic                       primary_undervoltage_interrupt,
  output logic                       aux_undervoltage_interrupt,
  output logic                       aux_overvoltage_interrupt,
  output logic                       aux_external_load_mode
);

  // ==========================================================================
  // Parameter check
  if (REG_ADDR_W < 6 || REG_ADDR_W > regsup_pkg::ADDR_W)
  begin : g_bad_addr
    $error("register address width out of range");
  end

  // ==========================================================================
  // Synchronised comparator and pin flags
  logic [regsup_pkg::SYNC_W-1:0] flags_async;
  logic [regsup_pkg::SYNC_W-1:0] flags;

  assign flags_async = {2'b00, external_reset_pin_b, variant_3v3, overtemp_warn_cmp, primary_below_cmp,
                        aux_below_90_cmp, aux_above_110_cmp, battery_undervoltage, battery_overvoltage};

  flag_sync
  #(
    .WIDTH      (regsup_pkg::SYNC_W),
    .RESET_BITS (regsup_pkg::SYNC_RESET)
  )
  u_sync
  (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (flags_async),
    .sync_out (flags)
  );

  logic       f_bat_ov;
  logic       f_bat_uv;
  logic       f_aux_ov;
  logic       f_aux_uv;
  logic [3:0] f_pri;
  logic       f_otw;
  logic       f_3v3;
  logic       f_ext_rst_b;

  assign f_bat_ov    = flags[regsup_pkg::S_BAT_OV];
  assign f_bat_uv    = flags[regsup_pkg::S_BAT_UV];
  assign f_aux_ov    = flags[regsup_pkg::S_AUX_OV];
  assign f_aux_uv    = flags[regsup_pkg::S_AUX_UV];
  assign f_pri       = flags[regsup_pkg::S_PRI_LSB +: 4];
  assign f_otw       = flags[regsup_pkg::S_OTW];
  assign f_3v3       = flags[regsup_pkg::S_VAR_3V3];
  assign f_ext_rst_b = flags[regsup_pkg::S_EXT_RST_B];

  // ==========================================================================
  // Secondary regulator mode table
  function automatic logic sec_on_in_mode(input logic [1:0] sel, input regsup_pkg::op_mode_t mode);
    logic on;
    on = 1'b0;
    case (mode)
      regsup_pkg::MODE_NORMAL    : on = (sel != 2'h0);
      regsup_pkg::MODE_STANDBY   : on = sel[1];
      regsup_pkg::MODE_RESET     : on = sel[1];
      regsup_pkg::MODE_SLEEP     : on = (sel == 2'h3);
      regsup_pkg::MODE_FAIL_SAFE : on = (sel == 2'h3);
      default                    : on = 1'b0;
    endcase
    return on;
  endfunction

  // ==========================================================================
  // State
  typedef struct packed
  {
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [7:0] status;
    logic [7:0] rdata;
    logic       ext_rst_prev;
    logic       pri90_prev;
    logic       aux_uv_prev;
    logic       aux_ov_prev;
    logic       sys_reset;
    logic       reduce;
    logic       sec_en;
    logic       pass_en;
    logic [1:0] thr_eff;
    logic       pri_int;
    logic       aux_uv_int;
    logic       aux_ov_int;
    logic       ext_load;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [1:0] thr_sel;
  logic [1:0] sec_sel;
  logic [1:0] policy;
  logic [1:0] thr_use;
  logic       ext_pulse;

  assign thr_sel   = st_r.ctrl[regsup_pkg::THR_LSB +: 2];
  assign sec_sel   = st_r.ctrl[regsup_pkg::SEC_EN_LSB +: 2];
  assign policy    = st_r.ctrl[regsup_pkg::POLICY_LSB +: 2];
  assign thr_use   = f_3v3 ? regsup_pkg::THR_90PCT : thr_sel;
  assign ext_pulse = st_r.ext_rst_prev && !f_ext_rst_b;

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_nxt              = st_r;
    st_nxt.ext_rst_prev = f_ext_rst_b;
    st_nxt.pri90_prev   = f_pri[0];
    st_nxt.aux_uv_prev  = f_aux_uv;
    st_nxt.aux_ov_prev  = f_aux_ov;

    // Register writes
    if (reg_wr && reg_addr == regsup_pkg::REG_CTRL_OFF[REG_ADDR_W-1:0])
    begin
      st_nxt.ctrl = reg_wdata & regsup_pkg::CTRL_WR_MASK;
    end
    if (reg_wr && reg_addr == regsup_pkg::REG_SUP_CFG_OFF[REG_ADDR_W-1:0])
    begin
      st_nxt.cfg = reg_wdata & regsup_pkg::CFG_WR_MASK;
    end
    if (ext_pulse)
    begin
      st_nxt.cfg[regsup_pkg::CFG_AUTO_REDUCE_BIT] = 1'b0;
    end

    // Status snapshot
    st_nxt.status                              = 8'h00;
    st_nxt.status[regsup_pkg::STAT_PRI_BIT]    = f_pri[0];
    st_nxt.status[regsup_pkg::STAT_AUX_UV_BIT] = f_aux_uv;
    st_nxt.status[regsup_pkg::STAT_AUX_OV_BIT] = f_aux_ov;
    st_nxt.status[regsup_pkg::STAT_OTW_BIT]    = f_otw;

    // Read data, unmapped reads zero
    case (reg_addr)
      regsup_pkg::REG_CTRL_OFF[REG_ADDR_W-1:0]    : st_nxt.rdata = st_r.ctrl & regsup_pkg::CTRL_WR_MASK;
      regsup_pkg::REG_SUP_CFG_OFF[REG_ADDR_W-1:0] : st_nxt.rdata = st_r.cfg;
      regsup_pkg::REG_STATUS_OFF[REG_ADDR_W-1:0]  : st_nxt.rdata = st_r.status;
      default                                     : st_nxt.rdata = 8'h00;
    endcase

    // Regulator outputs follow the stored control one cycle later
    st_nxt.thr_eff   = thr_use;
    st_nxt.sys_reset = f_pri[thr_use];
    st_nxt.reduce    = st_r.cfg[regsup_pkg::CFG_AUTO_REDUCE_BIT] && f_otw;
    st_nxt.sec_en    = sec_on_in_mode(sec_sel, op_mode)
                       && !(policy[0] && f_bat_uv)
                       && !(policy[1] && f_bat_ov);
    st_nxt.pass_en   = !f_aux_ov;
    st_nxt.ext_load  = !aux_connection_config;

    // Event pulses on entering a fault
    st_nxt.pri_int    = f_pri[0] && !st_r.pri90_prev
                        && st_r.cfg[regsup_pkg::CFG_PRI_UV_IE_BIT];
    st_nxt.aux_uv_int = f_aux_uv && !st_r.aux_uv_prev;
    st_nxt.aux_ov_int = f_aux_ov && !st_r.aux_ov_prev;

    // Power-up defaults
    if (!rst_b)
    begin
      st_nxt                                       = '0;
      st_nxt.ctrl[regsup_pkg::THR_LSB +: 2]        = primary_threshold_startup_default;
      st_nxt.ctrl[regsup_pkg::SEC_EN_LSB +: 2]     = secondary_startup_default;
      st_nxt.ctrl[regsup_pkg::POLICY_LSB +: 2]     = regsup_pkg::POLICY_RESET;
      st_nxt.cfg                                   = regsup_pkg::CFG_RESET;
      st_nxt.ext_rst_prev                          = 1'b1;
      st_nxt.sys_reset                             = 1'b1;
      st_nxt.pass_en                               = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    st_r <= st_nxt;
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata                      = st_r.rdata;
  assign system_reset                   = st_r.sys_reset;
  assign switched_mode_supply_setpoint_reduce_5v        = st_r.reduce;
  assign secondary_regulator_enable     = st_r.sec_en;
  assign aux_pass_enable                = st_r.pass_en;
  assign primary_reset_threshold_eff    = st_r.thr_eff;
  assign primary_undervoltage_interrupt = st_r.pri_int;
  assign aux_undervoltage_interrupt     = st_r.aux_uv_int;
  assign aux_overvoltage_interrupt      = st_r.aux_ov_int;
  assign aux_external_load_mode         = st_r.ext_load;

endmodule

// >>> tb/reg_host.sv
// Host software model driving the register port
`timescale 1ns/1ns
module reg_host
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            aux_connection_config
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    aux_connection_config = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
endmodule

// >>> tb/regsup_sva.sv
// Assertion checker for the regulator supervisor ports
`timescale 1ns/1ns
module regsup_sva
#(
  parameter int REG_ADDR_W = 8
)
(
  input wire logic                  ref_clk,
  input wire logic                  rst_b,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic                  reg_wr,
  input wire logic [7:0]            reg_wdata,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  variant_3v3,
  input wire logic                  overtemp_warn_cmp,
  input wire logic [3:0]            primary_below_cmp,
  input wire logic                  aux_above_110_cmp,
  input wire logic                  external_reset_pin_b,
  input wire logic                  system_reset,
  input wire logic                  switched_mode_supply_setpoint_reduce_5v,
  input wire logic                  aux_pass_enable,
  input wire logic [1:0]            primary_reset_threshold_eff,
  input wire logic                  primary_undervoltage_interrupt,
  input wire logic                  aux_overvoltage_interrupt
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Supervision
  property p_reduce;
    switched_mode_supply_setpoint_reduce_5v |-> $past(overtemp_warn_cmp, 3);
  endproperty
  a_reduce: assert property (p_reduce) else $error("Setpoint cut without warning");
  property p_pin_clear;
    $fell(external_reset_pin_b) |-> ##5 !switched_mode_supply_setpoint_reduce_5v;
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("Reduce kept after pin pulse");
  property p_sys_reset;
    ($stable(primary_below_cmp) && $stable(primary_reset_threshold_eff)) [*6]
      |-> system_reset == primary_below_cmp[primary_reset_threshold_eff];
  endproperty
  a_sys_reset: assert property (p_sys_reset) else $error("Reset level wrong");
  property p_fixed_thr;
    variant_3v3 [*5] |-> primary_reset_threshold_eff == 2'h0;
  endproperty
  a_fixed_thr: assert property (p_fixed_thr) else $error("Threshold not fixed");
  property p_thr_write;
    (!variant_3v3) [*4] ##0 (reg_wr && reg_addr == regsup_pkg::REG_CTRL_OFF)
      |-> ##2 primary_reset_threshold_eff == $past(reg_wdata[1:0], 2);
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("Threshold write late");
  property p_reserved;
    $past(reg_addr) == regsup_pkg::REG_CTRL_OFF |-> reg_rdata[7:6] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bits set");
  property p_pass;
    aux_pass_enable == !$past(aux_above_110_cmp, 3);
  endproperty
  a_pass: assert property (p_pass) else $error("Pass transistor wrong");
  property p_ov_int;
    aux_overvoltage_interrupt == ($past(aux_above_110_cmp, 3) && !$past(aux_above_110_cmp, 4));
  endproperty
  a_ov_int: assert property (p_ov_int) else $error("Overvoltage pulse wrong");
  property p_pri_int;
    primary_undervoltage_interrupt |-> $past(primary_below_cmp[0], 3) && !$past(primary_below_cmp[0], 4);
  endproperty
  a_pri_int: assert property (p_pri_int) else $error("Primary pulse wrong");
  c_reduce: cover property (switched_mode_supply_setpoint_reduce_5v);
  c_ov: cover property (aux_overvoltage_interrupt);
  c_pri: cover property (primary_undervoltage_interrupt);
endmodule
bind regulator_supervisor_control regsup_sva
#(
  .REG_ADDR_W (REG_ADDR_W)
)
regsup_sva_i
(
  .ref_clk                        (ref_clk),
  .rst_b                          (rst_b),
  .reg_addr                       (reg_addr),
  .reg_wr                         (reg_wr),
  .reg_wdata                      (reg_wdata),
  .reg_rdata                      (reg_rdata),
  .variant_3v3                    (variant_3v3),
  .overtemp_warn_cmp              (overtemp_warn_cmp),
  .primary_below_cmp              (primary_below_cmp),
  .aux_above_110_cmp              (aux_above_110_cmp),
  .external_reset_pin_b           (external_reset_pin_b),
  .system_reset                   (system_reset),
  .switched_mode_supply_setpoint_reduce_5v        (switched_mode_supply_setpoint_reduce_5v),
  .aux_pass_enable                (aux_pass_enable),
  .primary_reset_threshold_eff    (primary_reset_threshold_eff),
  .primary_undervoltage_interrupt (primary_undervoltage_interrupt),
  .aux_overvoltage_interrupt      (aux_overvoltage_interrupt)
);

// >>> tb/regulator_supervisor_control_tb.sv
// Self-checking testbench for the regulator supervisor
`timescale 1ns/1ns
module regulator_supervisor_control_tb;
  logic                 ref_clk, rst_b, reg_wr, variant_3v3, overtemp_warn_cmp, aux_below_90_cmp;
  logic                 aux_above_110_cmp, battery_undervoltage, battery_overvoltage, external_reset_pin_b;
  logic                 aux_connection_config, system_reset, switched_mode_supply_setpoint_reduce_5v, aux_pass_enable;
  logic                 secondary_regulator_enable, aux_external_load_mode, primary_undervoltage_interrupt;
  logic                 aux_undervoltage_interrupt, aux_overvoltage_interrupt;
  logic [1:0]           primary_threshold_startup_default, secondary_startup_default, primary_reset_threshold_eff;
  logic [3:0]           primary_below_cmp;
  logic [7:0]           reg_addr, reg_wdata, reg_rdata, ctrl, cfg, d;
  logic [31:0]          r;
  regsup_pkg::op_mode_t op_mode;
  int                   seed, bad_count, cmp_count, cyc, pu_n, uv_n, ov_n;

  regulator_supervisor_control regulator_supervisor_control_i
  (
    .ref_clk                           (ref_clk),
    .rst_b                             (rst_b),
    .reg_addr                          (reg_addr),
    .reg_wr                            (reg_wr),
    .reg_wdata                         (reg_wdata),
    .reg_rdata                         (reg_rdata),
    .op_mode                           (op_mode),
    .primary_threshold_startup_default (primary_threshold_startup_default),
    .secondary_startup_default         (secondary_startup_default),
    .aux_connection_config             (aux_connection_config),
    .external_reset_pin_b              (external_reset_pin_b),
    .variant_3v3                       (variant_3v3),
    .overtemp_warn_cmp                 (overtemp_warn_cmp),
    .primary_below_cmp                 (primary_below_cmp),
    .aux_below_90_cmp                  (aux_below_90_cmp),
    .aux_above_110_cmp                 (aux_above_110_cmp),
    .battery_undervoltage              (battery_undervoltage),
    .battery_overvoltage               (battery_overvoltage),
    .system_reset                      (system_reset),
    .switched_mode_supply_setpoint_reduce_5v           (switched_mode_supply_setpoint_reduce_5v),
    .secondary_regulator_enable        (secondary_regulator_enable),
    .aux_pass_enable                   (aux_pass_enable),
    .primary_reset_threshold_eff       (primary_reset_threshold_eff),
    .primary_undervoltage_interrupt    (primary_undervoltage_interrupt),
    .aux_undervoltage_interrupt        (aux_undervoltage_interrupt),
    .aux_overvoltage_interrupt         (aux_overvoltage_interrupt),
    .aux_external_load_mode            (aux_external_load_mode)
  );
  reg_host host_i
  (
    .ref_clk               (ref_clk),
    .reg_rdata             (reg_rdata),
    .reg_addr              (reg_addr),
    .reg_wr                (reg_wr),
    .reg_wdata             (reg_wdata),
    .aux_connection_config (aux_connection_config)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    pu_n += primary_undervoltage_interrupt;
    uv_n += aux_undervoltage_interrupt;
    ov_n += aux_overvoltage_interrupt;
    if (cyc == 5000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic sec_f();
    logic on;
    if (op_mode == regsup_pkg::MODE_NORMAL)
      on = ctrl[3:2] != 2'h0;
    else if (op_mode == regsup_pkg::MODE_STANDBY || op_mode == regsup_pkg::MODE_RESET)
      on = ctrl[3];
    else
      on = ctrl[3:2] == 2'h3;
    return on && !(ctrl[4] && battery_undervoltage) && !(ctrl[5] && battery_overvoltage);
  endfunction
  task automatic check_state();
    logic [1:0] e;
    repeat (5) @(negedge ref_clk);
    e = variant_3v3 ? 2'h0 : ctrl[1:0];
    host_i.rd(regsup_pkg::REG_CTRL_OFF, d);
    chk(d, ctrl);
    host_i.rd(regsup_pkg::REG_SUP_CFG_OFF, d);
    chk(d, cfg);
    host_i.rd(regsup_pkg::REG_STATUS_OFF, d);
    chk(d, {4'h0, overtemp_warn_cmp, aux_above_110_cmp, aux_below_90_cmp, primary_below_cmp[0]});
    chk(primary_reset_threshold_eff, e);
    chk(system_reset, primary_below_cmp[e]);
    chk(secondary_regulator_enable, sec_f());
    chk(switched_mode_supply_setpoint_reduce_5v, cfg[0] & overtemp_warn_cmp);
    chk(aux_pass_enable, !aux_above_110_cmp);
    chk(aux_external_load_mode, 1'b1);
  endtask

  // ==========================================================================
  // Scenarios
  initial
  begin
    seed = 77523;
    r = $random(seed);
    rst_b = 1'b0;
    op_mode = regsup_pkg::MODE_NORMAL;
    {primary_threshold_startup_default, secondary_startup_default} = r[3:0];
    {variant_3v3, overtemp_warn_cmp, primary_below_cmp, aux_below_90_cmp, aux_above_110_cmp} = 8'h00;
    {battery_undervoltage, battery_overvoltage} = 2'h0;
    external_reset_pin_b = 1'b1;
    ctrl = {4'h0, r[1:0], r[3:2]};
    cfg = 8'h00;
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    check_state();
    host_i.rd(8'h7F, d);
    chk(d, 8'h00);
    $display("test done: power-up defaults");
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      primary_below_cmp = r[11:8];
      host_i.wr(regsup_pkg::REG_CTRL_OFF, {2'h3, r[5:2], i[1:0]});
      ctrl = {2'h0, r[5:2], i[1:0]};
      check_state();
    end
    $display("test done: thresholds");
    for (int i = 0; i < 20; i++)
    begin
      r = $random(seed);
      op_mode = regsup_pkg::op_mode_t'(5'h01 << (i % 5));
      {battery_undervoltage, battery_overvoltage} = r[1:0];
      ctrl = {2'h0, i[1:0], 2'(i / 5), r[3:2]};
      host_i.wr(regsup_pkg::REG_CTRL_OFF, ctrl);
      check_state();
    end
    $display("test done: secondary table");
    op_mode = regsup_pkg::MODE_NORMAL;
    overtemp_warn_cmp = 1'b1;
    host_i.wr(regsup_pkg::REG_SUP_CFG_OFF, 8'hFF);
    cfg = 8'h03;
    check_state();
    external_reset_pin_b = 1'b0;
    repeat (3) @(negedge ref_clk);
    external_reset_pin_b = 1'b1;
    cfg = 8'h02;
    check_state();
    $display("test done: overtemperature");
    overtemp_warn_cmp = 1'b0;
    primary_below_cmp = 4'h0;
    repeat (5) @(negedge ref_clk);
    pu_n = 0;
    uv_n = 0;
    ov_n = 0;
    primary_below_cmp = 4'h1;
    aux_above_110_cmp = 1'b1;
    check_state();
    aux_above_110_cmp = 1'b0;
    aux_below_90_cmp = 1'b1;
    check_state();
    chk(8'(pu_n), 8'h01);
    chk(8'(ov_n), 8'h01);
    chk(8'(uv_n), 8'h01);
    $display("test done: supply events");
    variant_3v3 = 1'b1;
    host_i.wr(regsup_pkg::REG_CTRL_OFF, 8'h03);
    ctrl = 8'h03;
    check_state();
    $display("test done: fixed threshold");
    wrap_up();
  end
endmodule
